/* File: pkg/xiobc_pkg.sv */
package xiobc_pkg;
    // register byte offsets
    localparam logic [7:0] XIOBC_DIR_OFS   = 8'h00;
    localparam logic [7:0] XIOBC_BITC_OFS  = 8'h04;
    localparam logic [7:0] XIOBC_MAIN_OFS  = 8'h08;
    localparam logic [7:0] XIOBC_GRPA_OFS  = 8'h0c;
    localparam logic [7:0] XIOBC_SAVE_OFS  = 8'h1c;
    localparam logic [7:0] XIOBC_BLKR_OFS  = 8'h20;
    localparam logic [7:0] XIOBC_QRY_OFS   = 8'h24;
    localparam logic [7:0] XIOBC_GRP_STEP  = 8'h04;

    // geometry
    localparam int unsigned XIOBC_NBLK     = 8;
    localparam int unsigned XIOBC_BLK_W    = 8;
    localparam int unsigned XIOBC_EXT_W    = 64;
    localparam int unsigned XIOBC_GEN_W    = 8;
    localparam int unsigned XIOBC_GRP_W    = 16;
    localparam int unsigned XIOBC_NGRP     = 4;
    localparam int unsigned XIOBC_IMG_W    = 128;
    localparam int unsigned XIOBC_PAD_W    = 47;

    // point index ranges and block numbers
    localparam logic [7:0] XIOBC_GEN_FIRST = 8'h01;
    localparam logic [7:0] XIOBC_GEN_LAST  = 8'h08;
    localparam logic [7:0] XIOBC_EXT_FIRST = 8'h11;
    localparam logic [7:0] XIOBC_EXT_LAST  = 8'h50;
    localparam logic [3:0] XIOBC_MAIN_BLK  = 4'h0;
    localparam logic [3:0] XIOBC_BLK_FIRST = 4'h2;
    localparam logic [3:0] XIOBC_BLK_LAST  = 4'h9;

    // field positions
    localparam int unsigned XIOBC_IDX_LSB  = 0;
    localparam int unsigned XIOBC_OP_LSB   = 8;
    localparam int unsigned XIOBC_COND_BIT = 16;
    localparam int unsigned XIOBC_BAD_BIT  = 16;
    localparam int unsigned XIOBC_SEL_LSB  = 8;

    // reset values
    localparam logic [7:0]  XIOBC_DIR_RST  = 8'h00;
    localparam logic [7:0]  XIOBC_GEN_RST  = 8'h00;
    localparam logic [63:0] XIOBC_EXT_RST  = 64'h0;

    typedef enum logic [1:0] {
        XIOBC_OP_NONE = 2'b00,
        XIOBC_OP_SET  = 2'b01,
        XIOBC_OP_CLR  = 2'b10,
        XIOBC_OP_COND = 2'b11
    } xiobc_bitop_t;
endpackage

/* File: hdl/xiobc_top.sv */
`timescale 1ns/10ps
// What this block does
// (R1) sixty-four extended points in eight blocks of eight, blocks 2-9, bits 17-80.
// (R2) each block is output when its direction mask bit is one, input when zero.
// (R3) mask bit 0 steers block 2 and mask bit 7 steers block 9.
// (R4) with nothing saved the direction mask comes up zero, all blocks input.
// (R5) a save command stores direction and output states in nonvolatile memory.
// (R6) set and clear commands drive one output point high or low, 1-8 or 17-80.
// (R7) a conditional write sets one point to the supplied condition, same ranges.
// (R8) group output write has an 8-bit main argument and four 16-bit arguments.
// (R9) the four 16-bit arguments cover bits 17-32, 33-48, 49-64, 65-80, lsb first.
// (R10) group write bits landing on input blocks are ignored.
// (R11) every bit of a given argument is written, omitted arguments leave outputs.
// (R12) block read returns the eight point states of block 0 or 2 through 9.
// (R13) a bit query returns the present state of point 1-8 or 17-80.
// (R14) the commander builds the mask by adding weight 1 for block 2 to 128 for 9.
// (R15) a pad is driven only while its block is an output.
// (R16) output latches hold while their block is input and show again later.
module xiobc_top (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic      [7:0]  GEN_OUT,
    input  wire logic [63:0] EXT_IN,
    output logic      [63:0] EXT_OUT,
    output logic      [63:0] EXT_OE,
    output logic             NV_SAVE,
    output logic      [7:0]  NV_DIR_OUT,
    output logic      [7:0]  NV_GEN_OUT,
    output logic      [63:0] NV_EXT_OUT,
    input  wire logic        NV_VALID,
    input  wire logic [7:0]  NV_DIR_IN,
    input  wire logic [7:0]  NV_GEN_IN,
    input  wire logic [63:0] NV_EXT_IN
);
    import xiobc_pkg::*;

    function automatic logic point_ok(input logic [7:0] idx);
        point_ok = (idx >= XIOBC_GEN_FIRST && idx <= XIOBC_GEN_LAST) ||
                   (idx >= XIOBC_EXT_FIRST && idx <= XIOBC_EXT_LAST);
    endfunction

    function automatic logic block_ok(input logic [3:0] sel);
        block_ok = (sel == XIOBC_MAIN_BLK) ||
                   (sel >= XIOBC_BLK_FIRST && sel <= XIOBC_BLK_LAST);
    endfunction

    // architectural state and next values
    logic [7:0]  dir_r;
    logic [7:0]  gen_r;
    logic [63:0] ext_r;
    logic [63:0] ext_nxt;
    logic [7:0]  gen_nxt;
    logic [7:0]  dir_nxt;
    logic        restore_r;

    // pad synchroniser
    logic [63:0] in_s1_r;
    logic [63:0] in_s2_r;

    // read selectors
    logic [3:0]  blk_sel_r;
    logic [7:0]  qry_idx_r;

    // nonvolatile snapshot
    logic        nv_save_r;
    logic [7:0]  nv_dir_r;
    logic [7:0]  nv_gen_r;
    logic [63:0] nv_ext_r;

    // bus answer
    logic [31:0] prdata_r;
    logic        pslverr_r;

    // bus phases
    // ready is tied high, so every access phase lasts one cycle
    wire         setup_w   = PSEL & ~PENABLE;
    wire         wr_w      = PSEL & PENABLE & PWRITE;
    wire         hit_dir   = (PADDR == XIOBC_DIR_OFS);
    wire         hit_bitc  = (PADDR == XIOBC_BITC_OFS);
    wire         hit_main  = (PADDR == XIOBC_MAIN_OFS);
    wire         hit_save  = (PADDR == XIOBC_SAVE_OFS);
    wire         hit_blkr  = (PADDR == XIOBC_BLKR_OFS);
    wire         hit_qry   = (PADDR == XIOBC_QRY_OFS);
    logic [3:0]  hit_grp;
    wire         hit_any   = hit_dir | hit_bitc | hit_main | hit_save |
                             hit_blkr | hit_qry | (|hit_grp);

    // write strobes, one per register
    wire         wr_dir_w  = wr_w & hit_dir;
    wire         wr_bitc_w = wr_w & hit_bitc;
    wire         wr_main_w = wr_w & hit_main;
    wire         wr_save_w = wr_w & hit_save;
    wire         wr_blkr_w = wr_w & hit_blkr;
    wire         wr_qry_w  = wr_w & hit_qry;

    // block direction fans out to eight pads each
    logic [63:0] oe_w;
    genvar gb;
    generate
        for (gb = 0; gb < XIOBC_NBLK; gb++) begin : g_blk
            assign oe_w[gb*XIOBC_BLK_W +: XIOBC_BLK_W] =
                {XIOBC_BLK_W{dir_r[gb]}}; // [R2] [R3] [R1]
        end
    endgenerate

    // present point state: latch for outputs, synced pad for inputs
    wire [63:0] ext_state_w = (ext_r & oe_w) | (in_s2_r & ~oe_w);

    // point images indexed directly by point number 1..80
    // unused image bits are tied low and never selected
    wire [127:0] state_img_w = {{XIOBC_PAD_W{1'b0}}, ext_state_w,
                                8'h00, gen_r, 1'b0};
    wire [127:0] latch_img_w = {{XIOBC_PAD_W{1'b0}}, ext_r,
                                8'h00, gen_r, 1'b0};
    wire [127:0] wmask_img_w = {{XIOBC_PAD_W{1'b0}}, oe_w,
                                8'h00, 8'hff, 1'b0};

    // single-bit command decode
    wire [7:0]    bit_idx_w  = PWDATA[XIOBC_IDX_LSB +: 8];
    xiobc_bitop_t bit_op_w;
    assign bit_op_w = xiobc_bitop_t'(PWDATA[XIOBC_OP_LSB +: 2]);
    // condition bit only matters for the conditional op
    wire          bit_val_w  = (bit_op_w == XIOBC_OP_SET) ||
                               ((bit_op_w == XIOBC_OP_COND) &&
                                PWDATA[XIOBC_COND_BIT]); // [R7]
    wire          bit_go_w   = wr_bitc_w & point_ok(bit_idx_w) &
                               (bit_op_w != XIOBC_OP_NONE);
    // input blocks drop out of the mask, so their latches stay
    wire [127:0]  bit_hot_w  = (128'h1 << bit_idx_w) & wmask_img_w;
    wire [127:0]  bit_img_w  = bit_val_w ? (latch_img_w | bit_hot_w)
                                         : (latch_img_w & ~bit_hot_w); // [R6]

    // group writes: each argument is its own register, so an omitted
    // argument is simply a register that is not written
    logic [63:0] ext_grp_w;
    genvar gg;
    generate
        for (gg = 0; gg < XIOBC_NGRP; gg++) begin : g_grp
            assign hit_grp[gg] = (PADDR == XIOBC_GRPA_OFS +
                                  8'(gg) * XIOBC_GRP_STEP);
            assign ext_grp_w[gg*XIOBC_GRP_W +: XIOBC_GRP_W] =
                (wr_w & hit_grp[gg])
                ? ((ext_r[gg*XIOBC_GRP_W +: XIOBC_GRP_W] &
                    ~oe_w[gg*XIOBC_GRP_W +: XIOBC_GRP_W]) |
                   (PWDATA[XIOBC_GRP_W-1:0] &
                    oe_w[gg*XIOBC_GRP_W +: XIOBC_GRP_W])) // [R9] [R10] [R11]
                : ext_r[gg*XIOBC_GRP_W +: XIOBC_GRP_W];
        end
    endgenerate

    // next-state selection; restore after reset wins over any access
    wire nv_take_w = restore_r & NV_VALID;
    assign dir_nxt = nv_take_w ? NV_DIR_IN
                   : wr_dir_w ? PWDATA[7:0] : dir_r; // [R2]
    assign gen_nxt = nv_take_w ? NV_GEN_IN
                   : bit_go_w ? bit_img_w[8:1]
                   : wr_main_w ? PWDATA[7:0] : gen_r; // [R8]
    // a bit command and a group write never share a cycle
    assign ext_nxt = nv_take_w ? NV_EXT_IN
                   : bit_go_w ? bit_img_w[80:17] : ext_grp_w; // [R6] [R16]

    // block read and bit query answers
    wire [3:0]  sel_w     = PWDATA[3:0];
    wire        blk_main  = (blk_sel_r == XIOBC_MAIN_BLK);
    wire [3:0]  blk_ofs   = blk_sel_r - XIOBC_BLK_FIRST;
    wire [7:0]  blk_val_w = !block_ok(blk_sel_r) ? 8'h00
                          : blk_main ? gen_r
                          : ext_state_w[blk_ofs[2:0]*XIOBC_BLK_W +:
                                        XIOBC_BLK_W]; // [R12]
    wire [31:0] blk_rd_w  = {15'h0, ~block_ok(blk_sel_r), 4'h0,
                             blk_sel_r, blk_val_w};

    // bit query answer
    wire [31:0] qry_rd_w  = {15'h0, ~point_ok(qry_idx_r), 15'h0,
                             point_ok(qry_idx_r) &
                             state_img_w[qry_idx_r[6:0]]}; // [R13]

    // register read mux; group reads show latches, not pad states
    logic [1:0] grp_num_w;
    assign grp_num_w = hit_grp[3] ? 2'h3 : hit_grp[2] ? 2'h2
                     : hit_grp[1] ? 2'h1 : 2'h0;
    wire [31:0] rd_mux_w  = hit_dir  ? {24'h0, dir_r}
                          : hit_main ? {24'h0, gen_r}
                          : (|hit_grp) ? {16'h0,
                                ext_r[grp_num_w*XIOBC_GRP_W +: XIOBC_GRP_W]}
                          : hit_blkr ? blk_rd_w
                          : hit_qry  ? qry_rd_w
                          : 32'h0;

    // error decode: unmapped address, bad index or bad selector
    wire        bad_bit_w = hit_bitc & ~point_ok(bit_idx_w);
    wire        bad_blk_w = hit_blkr & ~block_ok(sel_w);
    wire        bad_qry_w = hit_qry & ~point_ok(bit_idx_w);
    wire        err_w     = ~hit_any |
                            (PWRITE & (bad_bit_w | bad_blk_w | bad_qry_w));

    // pads pass two flops before anything reads them
    // no reset: the chain only follows the pads
    always_ff @(posedge CLK) begin
        in_s1_r <= EXT_IN;
        in_s2_r <= in_s1_r;
    end

    // direction mask, zero until restored or written
    always_ff @(posedge CLK) begin
        if (SYS_RST)
            dir_r <= XIOBC_DIR_RST; // [R4]
        else
            dir_r <= dir_nxt;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST)
            gen_r <= XIOBC_GEN_RST;
        else
            gen_r <= gen_nxt;
    end

    // latches keep their value whatever the direction
    always_ff @(posedge CLK) begin
        if (SYS_RST)
            ext_r <= XIOBC_EXT_RST;
        else
            ext_r <= ext_nxt; // [R16]
    end

    // restore window is the single cycle after reset
    always_ff @(posedge CLK) begin
        if (SYS_RST)
            restore_r <= 1'b1;
        else
            restore_r <= 1'b0; // [R4]
    end

    // selectors are kept even when flagged bad, reads then show the flag
    always_ff @(posedge CLK) begin
        if (SYS_RST)
            blk_sel_r <= XIOBC_MAIN_BLK;
        else if (wr_blkr_w)
            blk_sel_r <= sel_w; // [R12]
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST)
            qry_idx_r <= XIOBC_GEN_FIRST;
        else if (wr_qry_w)
            qry_idx_r <= bit_idx_w; // [R13]
    end

    // snapshot taken before the save write changes anything
    always_ff @(posedge CLK) begin
        if (SYS_RST)
            nv_save_r <= 1'b0;
        else
            nv_save_r <= wr_save_w; // [R5]
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            nv_dir_r <= XIOBC_DIR_RST;
            nv_gen_r <= XIOBC_GEN_RST;
            nv_ext_r <= XIOBC_EXT_RST;
        end else if (wr_save_w) begin
            nv_dir_r <= dir_r; // [R5]
            nv_gen_r <= gen_r;
            nv_ext_r <= ext_r;
        end
    end

    // read data and error caught in setup, so access needs no wait
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            prdata_r  <= 32'h0;
            pslverr_r <= 1'b0;
        end else if (setup_w) begin
            prdata_r  <= PWRITE ? 32'h0 : rd_mux_w;
            pslverr_r <= err_w;
        end
    end

    // bus answer
    assign PRDATA     = prdata_r;
    assign PREADY     = 1'b1;
    assign PSLVERR    = PSEL & PENABLE & pslverr_r;

    // pads; input blocks never show a drive value
    assign GEN_OUT    = gen_r;
    assign EXT_OUT    = ext_r & oe_w; // [R15]
    assign EXT_OE     = oe_w; // [R15]

    // nonvolatile side
    assign NV_SAVE    = nv_save_r;
    assign NV_DIR_OUT = nv_dir_r;
    assign NV_GEN_OUT = nv_gen_r;
    assign NV_EXT_OUT = nv_ext_r;
endmodule

/* File: bench/xiobc_chk.sv */
`timescale 1ns/10ps
module xiobc_chk (
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PSLVERR,
    input wire logic [7:0]  GEN_OUT,
    input wire logic [63:0] EXT_OUT,
    input wire logic [63:0] EXT_OE,
    input wire logic        NV_SAVE,
    input wire logic [7:0]  NV_DIR_OUT
);
    logic [63:0] oe_exp;
    logic [7:0]  dir_now;
    logic [6:0]  pt;
    logic        acc;
    logic        ext_idx;
    logic        ok_idx;
    assign acc = PSEL && PENABLE && PWRITE;
    assign pt = 7'(PWDATA[7:0] - 8'h11);
    assign ext_idx = PWDATA[7:0] >= 8'h11 && PWDATA[7:0] <= 8'h50;
    assign ok_idx = ext_idx || (PWDATA[7:0] >= 8'h01 && PWDATA[7:0] <= 8'h08);
    always_comb begin
        for (int i = 0; i < 64; i++) begin
            oe_exp[i] = PWDATA[i/8];
        end
        for (int b = 0; b < 8; b++) begin
            dir_now[b] = EXT_OE[8*b];
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    a_dir_sets_oe: assert property (acc && PADDR == 8'h00 |=>
        EXT_OE == $past(oe_exp)) else $error("enables differ from mask");
    a_pad_gated: assert property ((EXT_OUT & ~EXT_OE) == 64'h0)
        else $error("pad driven in input block");
    a_reset_idle: assert property (disable iff (1'b0) SYS_RST |=>
        EXT_OE == 64'h0 && GEN_OUT == 8'h0 && !NV_SAVE)
        else $error("not idle after reset");
    a_save_pulse: assert property (acc && PADDR == 8'h1c |=>
        NV_SAVE && NV_DIR_OUT == $past(dir_now) ##1 !NV_SAVE)
        else $error("save pulse or snapshot wrong");
    a_bad_index: assert property (PSEL && !PENABLE && PWRITE &&
        PADDR == 8'h04 && !ok_idx ##1 PENABLE |-> PSLVERR)
        else $error("bad index not flagged");
    a_main_write: assert property (acc && PADDR == 8'h08 |=>
        GEN_OUT == $past(PWDATA[7:0])) else $error("main outputs wrong");
    a_bit_setclr: assert property (acc && PADDR == 8'h04 && ext_idx &&
        PWDATA[9:8] inside {2'b01, 2'b10} && EXT_OE[pt] |=>
        EXT_OUT[$past(pt)] == $past(PWDATA[8])) else $error("set or clear");
    a_bit_cond: assert property (acc && PADDR == 8'h04 && ext_idx &&
        PWDATA[9:8] == 2'b11 && EXT_OE[pt] |=>
        EXT_OUT[$past(pt)] == $past(PWDATA[16])) else $error("cond write");
    a_group_low: assert property (acc && PADDR == 8'h0c |=>
        EXT_OUT[15:0] == $past(PWDATA[15:0] & EXT_OE[15:0]) &&
        $stable(EXT_OUT[63:16])) else $error("group write wrong");
endmodule
bind xiobc_top xiobc_chk xiobc_chk_i (.CLK(CLK), .SYS_RST(SYS_RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSLVERR(PSLVERR), .GEN_OUT(GEN_OUT),
    .EXT_OUT(EXT_OUT), .EXT_OE(EXT_OE), .NV_SAVE(NV_SAVE),
    .NV_DIR_OUT(NV_DIR_OUT));

/* File: bench/xiobc_rack.sv */
`timescale 1ns/10ps
module xiobc_rack (
    input  wire logic [63:0] ext_oe,
    input  wire logic [63:0] ext_out,
    input  wire logic [63:0] field,
    output logic      [63:0] ext_in
);
    // undriven points show the field level, never a stale drive value
    assign ext_in = (ext_oe & ext_out) | (~ext_oe & field);
endmodule

/* File: bench/tb.sv */
`timescale 1ns/10ps
module tb;
    import xiobc_pkg::*;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        nv_valid = 0, pready, pslverr, nv_save, err;
    logic [7:0]  paddr = 0, nv_dir = 0, nv_gen = 0, gen_out, nv_dir_o, nv_gen_o;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [63:0] nv_ext = 0, field = 64'h0123_4567_89ab_cd5a;
    logic [63:0] ext_in, ext_out, ext_oe, nv_ext_o;
    int          n_fail = 0, check_count = 0;
    xiobc_top xiobc_top_i (.CLK(clk), .SYS_RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .GEN_OUT(gen_out), .EXT_IN(ext_in), .EXT_OUT(ext_out),
        .EXT_OE(ext_oe), .NV_SAVE(nv_save), .NV_DIR_OUT(nv_dir_o),
        .NV_GEN_OUT(nv_gen_o), .NV_EXT_OUT(nv_ext_o), .NV_VALID(nv_valid),
        .NV_DIR_IN(nv_dir), .NV_GEN_IN(nv_gen), .NV_EXT_IN(nv_ext));
    xiobc_rack xiobc_rack_i (.ext_oe(ext_oe), .ext_out(ext_out),
        .field(field), .ext_in(ext_in));
    initial begin
        forever #50 clk = ~clk;
    end
    task chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task do_reset(input logic v);
        @(posedge clk);
        nv_valid <= v;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    task t_dir;
        chk(ext_oe, 64'h0);
        apb(0, XIOBC_DIR_OFS, 0);
        chk(rd, 0);
        for (int b = 0; b < 8; b++) begin
            apb(1, XIOBC_DIR_OFS, 32'h1 << b);
            @(negedge clk);
            chk(ext_oe, 64'hff << (8 * b));
        end
        apb(1, XIOBC_DIR_OFS, 32'h0c); // weights 4 and 8: blocks 4, 5
    endtask
    task t_out;
        apb(1, XIOBC_MAIN_OFS, 32'h7);
        apb(1, XIOBC_GRPA_OFS + XIOBC_GRP_STEP, 32'h0007);
        apb(1, XIOBC_GRPA_OFS, 32'hffff);
        @(negedge clk);
        chk(gen_out, 8'h07);
        chk(ext_out, 64'h0007_0000);
        apb(1, XIOBC_BITC_OFS, 32'h0128);
        apb(1, XIOBC_BITC_OFS, 32'h0221);
        apb(1, XIOBC_BITC_OFS, 32'h1_0329);
        apb(1, XIOBC_BITC_OFS, 32'h0201);
        @(negedge clk);
        chk(ext_out, 64'h0186_0000);
        chk(gen_out, 8'h06);
        apb(1, XIOBC_BITC_OFS, 32'h0109);
        chk(err, 1'b1);
    endtask
    task t_read;
        apb(1, XIOBC_BLKR_OFS, 2);
        apb(0, XIOBC_BLKR_OFS, 0);
        chk(rd[7:0], 8'h5a);
        apb(1, XIOBC_BLKR_OFS, 4);
        apb(0, XIOBC_BLKR_OFS, 0);
        chk(rd[7:0], 8'h86);
        apb(1, XIOBC_BLKR_OFS, 0);
        apb(0, XIOBC_BLKR_OFS, 0);
        chk(rd[7:0], 8'h06);
        apb(1, XIOBC_QRY_OFS, 32'h12);
        apb(0, XIOBC_QRY_OFS, 0);
        chk(rd[0], 1'b1);
        apb(1, XIOBC_QRY_OFS, 32'h29);
        apb(0, XIOBC_QRY_OFS, 0);
        chk(rd[0], 1'b1);
    endtask
    task t_hold;
        int n;
        apb(1, XIOBC_DIR_OFS, 0);
        @(negedge clk);
        chk(ext_out, 64'h0);
        apb(0, XIOBC_GRPA_OFS + XIOBC_GRP_STEP, 0);
        chk(rd[15:0], 16'h0186);
        apb(1, XIOBC_DIR_OFS, 32'h0c);
        @(negedge clk);
        chk(ext_out, 64'h0186_0000);
        apb(1, XIOBC_SAVE_OFS, 0);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (nv_save !== 1'b1 && n < 10);
        chk(nv_save, 1'b1);
        chk(nv_dir_o, 8'h0c);
        chk(nv_gen_o, 8'h06);
        chk(nv_ext_o[31:16], 16'h0186);
    endtask
    task t_restore;
        @(posedge clk);
        nv_dir <= 8'h81;
        nv_gen <= 8'h3c;
        nv_ext <= '1;
        do_reset(1'b1);
        chk(ext_oe, 64'hff00_0000_0000_00ff);
        chk(ext_out, 64'hff00_0000_0000_00ff);
        chk(gen_out, 8'h3c);
        apb(1, XIOBC_GRPA_OFS + 8'h03 * XIOBC_GRP_STEP, 32'habcd);
        @(negedge clk);
        chk(ext_out[63:48], 16'hab00);
        apb(0, XIOBC_GRPA_OFS + 8'h03 * XIOBC_GRP_STEP, 0);
        chk(rd[15:0], 16'habff);
        do_reset(1'b0);
        chk(ext_oe, 64'h0);
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        end_of_test;
    end
    initial begin
        do_reset(1'b0);
        t_dir;
        t_out;
        t_read;
        t_hold;
        t_restore;
        end_of_test;
    end
endmodule
